// *** verilog/ogt_pkg.sv ***
// Purpose: Shared constants for the output gate and trigger input block
// Assumes: pclk at 125 MHz, APB3 register access with 32-bit data
// Notes:   Times are held in their own unit, cycle counts are derived
//
// Summary of operation
// - Gate pin runs in one of six modes, set by panel or command.
// - After reset the gate pin mode is brief-low-disable.
// - Brief-low-disable: gate low for 100 us disables output, enters standby.
// - Brief-low-disable: gate high never re-enables; only key or on-command.
// - Response to a qualified gate level completes well within 200 ms.
// - High-enables: output on while gate high or open and output enabled, off while low.
// - First low-level mode: output off while gate low; high follows enable state.
// - Low latch-off: gate low latches output off until key or on-command.
// - High latch-off: gate high latches output off until key or on-command.
// - Ignored mode: gate pin level has no effect at all.
// - Trigger pin low fires one trigger event.
// - Trigger pin high rearms; no further event until rearmed.

package ogt_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned GATE_QUAL_US      = 100;
  localparam int unsigned GATE_QUAL_CYCLES  = (GATE_QUAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_QUAL_NS      = 1000;
  localparam int unsigned TRIG_QUAL_CYCLES  = (TRIG_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] MODE_OFFSET       = 8'h00;
  localparam logic [7:0] COMMAND_OFFSET    = 8'h04;
  localparam logic [7:0] STATUS_OFFSET     = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h14;
  localparam logic [7:0] TRIG_COUNT_OFFSET = 8'h18;

  // ****************************************
  // Gate mode codes
  // ****************************************
  localparam int unsigned  MODE_W                   = 3;
  localparam logic [2:0]   BRIEF_LOW_DISABLE_CODE   = 3'h0;
  localparam logic [2:0]   HIGH_ENABLES_CODE        = 3'h1;
  localparam logic [2:0]   FIRST_LOW_LEVEL_CODE     = 3'h2;
  localparam logic [2:0]   LOW_LATCH_OFF_CODE       = 3'h3;
  localparam logic [2:0]   HIGH_LATCH_OFF_CODE      = 3'h4;
  localparam logic [2:0]   IGNORED_CODE             = 3'h5;
  localparam logic [2:0]   MODE_RESET               = BRIEF_LOW_DISABLE_CODE;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CMD_ON_BIT        = 0;
  localparam int unsigned CMD_OFF_BIT       = 1;
  localparam int unsigned STAT_OUTPUT_BIT   = 0;
  localparam int unsigned STAT_LATCHED_BIT  = 1;
  localparam int unsigned STAT_GATE_BIT     = 2;
  localparam int unsigned STAT_TRIG_BIT     = 3;
  localparam int unsigned STAT_ARMED_BIT    = 4;
  localparam int unsigned IRQ_W             = 3;
  localparam int unsigned IRQ_TRIGGER_BIT   = 0;
  localparam int unsigned IRQ_GATE_OFF_BIT  = 1;
  localparam int unsigned IRQ_OUTPUT_ON_BIT = 2;
  localparam logic [2:0]  IRQ_ENABLE_RESET  = 3'h0;
  localparam logic [15:0] TRIG_COUNT_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    out_standby,
    out_enabled,
    out_latched
  } ogt_out_state_type;

endpackage : ogt_pkg

// *** verilog/ogt_qual_filter.sv ***
// Purpose: Two-flop synchroniser and stability filter for one pin
// Assumes: Pin may change at any time
// Notes:   Level follows the pin only after QUAL_CYCLES stable cycles
`timescale 1ns/1ps
`default_nettype none

module ogt_qual_filter #(
  parameter int unsigned QUAL_CYCLES = 1,
  parameter logic        IDLE_LEVEL  = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level
);

  localparam int unsigned CW = $clog2(QUAL_CYCLES + 1);

  logic          sync_first;
  logic          sync_second;
  logic [CW-1:0] stable_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first  <= IDLE_LEVEL;
      sync_second <= IDLE_LEVEL;
    end else begin
      sync_first  <= pin;
      sync_second <= sync_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_count <= '0;
    end else if (sync_second == level || stable_count == CW'(QUAL_CYCLES - 1)) begin
      // Restart on every flip, so a change right after it needs a full count again
      stable_count <= '0;
    end else begin
      stable_count <= stable_count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= IDLE_LEVEL;
    end else if (sync_second != level && stable_count == CW'(QUAL_CYCLES - 1)) begin
      level <= sync_second;
    end
  end

endmodule : ogt_qual_filter

`default_nettype wire

// *** verilog/ogt_irq_bank.sv ***
// Purpose: Sticky interrupt status with write-one clear and enable mask
// Assumes: Events are one-cycle pulses
// Notes:   A set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none

module ogt_irq_bank #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] events,
  input  wire logic             clear_we,
  input  wire logic             enable_we,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] status,
  output logic      [WIDTH-1:0] enable,
  output logic                  irq
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~(clear_we ? wdata : '0)) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= WIDTH'(ogt_pkg::IRQ_ENABLE_RESET);
    end else if (enable_we) begin
      enable <= wdata;
    end
  end

  assign irq = |(status & enable);

endmodule : ogt_irq_bank

`default_nettype wire

// *** verilog/ogt_top.sv ***
// Purpose: Output gate pin modes, trigger input and APB register access
// Assumes: Pins are plain logic levels; open gate pin reads high
// Notes:   Front panel mode changes and key presses arrive as pulses
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module ogt_top #(
  parameter int unsigned GATE_QUAL_CYCLES = ogt_pkg::GATE_QUAL_CYCLES,
  parameter int unsigned TRIG_QUAL_CYCLES = ogt_pkg::TRIG_QUAL_CYCLES,
  parameter int unsigned COUNT_W          = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gate_pin,
  input  wire logic        external_trigger_pin,
  input  wire logic        standby_key,
  input  wire logic        panel_mode_valid,
  input  wire logic [2:0]  panel_mode,
  output logic             output_enable,
  output logic             standby,
  output logic             trigger_event,
  output logic             irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                          gate_high;
  logic                          trig_high;
  logic [ogt_pkg::MODE_W-1:0]    gate_mode;
  ogt_pkg::ogt_out_state_type    out_state;
  ogt_pkg::ogt_out_state_type    next_out_state;
  logic                          next_output_enable;
  logic                          trigger_armed;
  logic [COUNT_W-1:0]            trigger_count;
  logic                          write_cycle;
  logic                          setup_cycle;
  logic                          addr_valid;
  logic                          mode_we;
  logic                          command_we;
  logic                          irq_clear_we;
  logic                          irq_enable_we;
  logic                          cmd_on;
  logic                          cmd_off;
  logic                          resume_request;
  logic                          latch_condition;
  logic                          level_block;
  logic                          fire_trigger;
  logic                          gate_off_event;
  logic                          output_on_event;
  logic [ogt_pkg::IRQ_W-1:0]     irq_events;
  logic [ogt_pkg::IRQ_W-1:0]     irq_status;
  logic [ogt_pkg::IRQ_W-1:0]     irq_enable;
  logic [31:0]                   read_value;
  logic [1:0]                    pin_in;
  logic [1:0]                    pin_level;

  // ****************************************
  // Pin qualification
  // ****************************************
  assign pin_in = {external_trigger_pin, gate_pin};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_pin
      localparam int unsigned QUAL = (i == 0) ? GATE_QUAL_CYCLES : TRIG_QUAL_CYCLES;
      ogt_qual_filter #(
        .QUAL_CYCLES (QUAL),
        .IDLE_LEVEL  (1'b1)
      ) u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pin_in[i]),
        .level   (pin_level[i])
      );
    end
  endgenerate

  assign gate_high = pin_level[0];
  assign trig_high = pin_level[1];

  // ****************************************
  // APB decode
  // ****************************************
  assign setup_cycle = psel && !penable;
  assign write_cycle = psel && penable && pwrite;

  always_comb begin
    case (paddr)
      ogt_pkg::MODE_OFFSET,
      ogt_pkg::COMMAND_OFFSET,
      ogt_pkg::STATUS_OFFSET,
      ogt_pkg::IRQ_STATUS_OFFSET,
      ogt_pkg::IRQ_CLEAR_OFFSET,
      ogt_pkg::IRQ_ENABLE_OFFSET,
      ogt_pkg::TRIG_COUNT_OFFSET: addr_valid = 1'b1;
      default:                    addr_valid = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_valid;

  assign mode_we       = write_cycle && (paddr == ogt_pkg::MODE_OFFSET);
  assign command_we    = write_cycle && (paddr == ogt_pkg::COMMAND_OFFSET);
  assign irq_clear_we  = write_cycle && (paddr == ogt_pkg::IRQ_CLEAR_OFFSET);
  assign irq_enable_we = write_cycle && (paddr == ogt_pkg::IRQ_ENABLE_OFFSET);

  assign cmd_on  = command_we && pwdata[ogt_pkg::CMD_ON_BIT];
  assign cmd_off = command_we && pwdata[ogt_pkg::CMD_OFF_BIT];

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    read_value = 32'h0000_0000;
    case (paddr)
      ogt_pkg::MODE_OFFSET: begin
        read_value[ogt_pkg::MODE_W-1:0] = gate_mode;
      end
      ogt_pkg::STATUS_OFFSET: begin
        read_value[ogt_pkg::STAT_OUTPUT_BIT]  = output_enable;
        read_value[ogt_pkg::STAT_LATCHED_BIT] = (out_state == ogt_pkg::out_latched);
        read_value[ogt_pkg::STAT_GATE_BIT]    = gate_high;
        read_value[ogt_pkg::STAT_TRIG_BIT]    = trig_high;
        read_value[ogt_pkg::STAT_ARMED_BIT]   = trigger_armed;
      end
      ogt_pkg::IRQ_STATUS_OFFSET: begin
        read_value[ogt_pkg::IRQ_W-1:0] = irq_status;
      end
      ogt_pkg::IRQ_ENABLE_OFFSET: begin
        read_value[ogt_pkg::IRQ_W-1:0] = irq_enable;
      end
      ogt_pkg::TRIG_COUNT_OFFSET: begin
        read_value[COUNT_W-1:0] = trigger_count;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the setup cycle, valid through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_cycle && !pwrite) begin
      prdata <= read_value;
    end
  end

  // ****************************************
  // Gate mode register
  // ****************************************
  // Unknown codes are ignored, register keeps its mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_mode <= ogt_pkg::MODE_RESET;
    end else if (mode_we && pwdata[ogt_pkg::MODE_W-1:0] <= ogt_pkg::IGNORED_CODE) begin
      gate_mode <= pwdata[ogt_pkg::MODE_W-1:0];
    end else if (!mode_we && panel_mode_valid && panel_mode <= ogt_pkg::IGNORED_CODE) begin
      gate_mode <= panel_mode;
    end
  end

  // ****************************************
  // Gate conditions
  // ****************************************
  always_comb begin
    latch_condition = 1'b0;
    level_block     = 1'b0;
    case (gate_mode)
      ogt_pkg::BRIEF_LOW_DISABLE_CODE: begin
        latch_condition = !gate_high;
      end
      ogt_pkg::HIGH_ENABLES_CODE: begin
        level_block = !gate_high;
      end
      ogt_pkg::FIRST_LOW_LEVEL_CODE: begin
        level_block = !gate_high;
      end
      ogt_pkg::LOW_LATCH_OFF_CODE: begin
        latch_condition = !gate_high;
      end
      ogt_pkg::HIGH_LATCH_OFF_CODE: begin
        latch_condition = gate_high;
      end
      ogt_pkg::IGNORED_CODE: begin
        latch_condition = 1'b0;
      end
      default: begin
        latch_condition = 1'b0;
        level_block     = 1'b0;
      end
    endcase
  end

  // Standby key and on-command both leave latch and standby
  assign resume_request = cmd_on || standby_key;

  // ****************************************
  // Output state machine
  // ****************************************
  always_comb begin
    next_out_state = out_state;
    case (out_state)
      ogt_pkg::out_standby: begin
        if (resume_request) begin
          next_out_state = ogt_pkg::out_enabled;
        end
      end
      ogt_pkg::out_enabled: begin
        if (cmd_off || standby_key) begin
          next_out_state = ogt_pkg::out_standby;
        end
      end
      ogt_pkg::out_latched: begin
        if (resume_request) begin
          next_out_state = ogt_pkg::out_enabled;
        end
      end
      default: begin
        next_out_state = ogt_pkg::out_standby;
      end
    endcase
    // Active gate level holds or sets the latch, winning over resume
    if (latch_condition) begin
      next_out_state = ogt_pkg::out_latched;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_state <= ogt_pkg::out_standby;
    end else begin
      out_state <= next_out_state;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  assign next_output_enable = (next_out_state == ogt_pkg::out_enabled) && !level_block;

  // One cycle after a qualified level, far inside the response limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_enable <= 1'b0;
      standby       <= 1'b1;
    end else begin
      output_enable <= next_output_enable;
      standby       <= !next_output_enable;
    end
  end

  // ****************************************
  // Trigger input
  // ****************************************
  assign fire_trigger = trigger_armed && !trig_high;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_armed <= 1'b1;
    end else if (fire_trigger) begin
      trigger_armed <= 1'b0;
    end else if (trig_high) begin
      trigger_armed <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_event <= 1'b0;
    end else begin
      trigger_event <= fire_trigger;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_count <= COUNT_W'(ogt_pkg::TRIG_COUNT_RESET);
    end else if (fire_trigger) begin
      trigger_count <= trigger_count + 1'b1;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign gate_off_event  = output_enable && !next_output_enable &&
                           (latch_condition || level_block);
  assign output_on_event = !output_enable && next_output_enable;

  always_comb begin
    irq_events                            = '0;
    irq_events[ogt_pkg::IRQ_TRIGGER_BIT]   = fire_trigger;
    irq_events[ogt_pkg::IRQ_GATE_OFF_BIT]  = gate_off_event;
    irq_events[ogt_pkg::IRQ_OUTPUT_ON_BIT] = output_on_event;
  end

  ogt_irq_bank #(
    .WIDTH (ogt_pkg::IRQ_W)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .events    (irq_events),
    .clear_we  (irq_clear_we),
    .enable_we (irq_enable_we),
    .wdata     (pwdata[ogt_pkg::IRQ_W-1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

endmodule : ogt_top

`default_nettype wire

// *** test/ogt_checker.sv ***
// Purpose: Port-level assertions for the output gate and trigger block
// Assumes: One pclk domain, presetn asynchronous and active low
// Notes:   Bound onto ogt_top below the module
`timescale 1ns/1ps
`default_nettype none

module ogt_checker #(
  parameter int unsigned GATE_QUAL_CYCLES = 8,
  parameter int unsigned TRIG_QUAL_CYCLES = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        gate_pin,
  input wire logic        external_trigger_pin,
  input wire logic        standby_key,
  input wire logic        panel_mode_valid,
  input wire logic        output_enable,
  input wire logic        standby,
  input wire logic        trigger_event,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic apb_wr = psel && penable && pwrite;

  standby_inverse_a: assert property (standby != output_enable)
    else $error("standby is not the inverse of output enable");
  pready_high_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  prdata_hold_a: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data changed without a read setup");
  reset_state_a: assert property ($rose(presetn) |-> !output_enable && !trigger_event && !irq)
    else $error("outputs not idle after reset");
  trig_spacing_a: assert property (trigger_event |=> !trigger_event [*7])
    else $error("trigger event without rearm");
  trig_cause_a: assert property (trigger_event |-> !$past(external_trigger_pin, 4))
    else $error("trigger event without low trigger pin");
  out_on_cause_a: assert property ($rose(output_enable) |-> $past(standby_key) || $past(standby_key, 2)
    || $past(apb_wr) || $past(apb_wr, 2) || $past(panel_mode_valid) || $past(panel_mode_valid, 2)
    || $past(gate_pin, 4))
    else $error("output enabled without a cause");
  irq_cause_a: assert property ($rose(irq) |-> trigger_event || $changed(output_enable)
    || $past(apb_wr) || $past(apb_wr, 2))
    else $error("interrupt raised without an event");

  cover property (trigger_event);
  cover property ($fell(output_enable));
  cover property (pslverr);
endmodule : ogt_checker

bind ogt_top ogt_checker #(
  .GATE_QUAL_CYCLES(GATE_QUAL_CYCLES),
  .TRIG_QUAL_CYCLES(TRIG_QUAL_CYCLES)
) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_pin(gate_pin),
  .external_trigger_pin(external_trigger_pin), .standby_key(standby_key),
  .panel_mode_valid(panel_mode_valid), .output_enable(output_enable), .standby(standby),
  .trigger_event(trigger_event), .irq(irq)
);
`default_nettype wire

// *** test/ogt_ext_equipment.sv ***
// Purpose: External equipment driving the trigger port logic levels
// Assumes: Levels change just after a pclk edge; an open pin reads high
// Notes:   Hold times are given in pclk cycles by the caller
`timescale 1ns/1ps
`default_nettype none

module ogt_ext_equipment (
  input  wire logic pclk,
  output var logic  gate_pin,
  output var logic  external_trigger_pin
);
  initial begin
    gate_pin             = 1'b1;
    external_trigger_pin = 1'b1;
  end

  // Level held n cycles; a qualifying low is held past the filter time
  task automatic drive_gate(input logic lvl, input int unsigned n);
    @(posedge pclk);
    gate_pin <= lvl;
    repeat (n) @(posedge pclk);
  endtask : drive_gate

  task automatic drive_trig(input logic lvl, input int unsigned n);
    @(posedge pclk);
    external_trigger_pin <= lvl;
    repeat (n) @(posedge pclk);
  endtask : drive_trig
endmodule : ogt_ext_equipment
`default_nettype wire

// *** test/tb.sv ***
// Purpose: Self-checking bench for the output gate and trigger block
// Assumes: Short filter parameters, zero-wait APB slave
// Notes:   Mode table rows first, then hand-written cases
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        pclk, presetn, psel, penable, pwrite, standby_key, panel_mode_valid, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  panel_mode;
  logic        pready, pslverr, gate_pin, external_trigger_pin, output_enable, standby, trigger_event, irq;
  int          errors = 0, n_tests = 0, n_trig = 0;
  typedef struct packed {logic [2:0] mode; logic act; logic oe_act; logic oe_back;} ogt_row_type;
  ogt_row_type rows [6] = '{'{ogt_pkg::BRIEF_LOW_DISABLE_CODE, 1'b0, 1'b0, 1'b0},
    '{ogt_pkg::HIGH_ENABLES_CODE, 1'b0, 1'b0, 1'b1}, '{ogt_pkg::FIRST_LOW_LEVEL_CODE, 1'b0, 1'b0, 1'b1},
    '{ogt_pkg::LOW_LATCH_OFF_CODE, 1'b0, 1'b0, 1'b0}, '{ogt_pkg::HIGH_LATCH_OFF_CODE, 1'b1, 1'b0, 1'b0},
    '{ogt_pkg::IGNORED_CODE, 1'b0, 1'b1, 1'b1}};

  ogt_top #(.GATE_QUAL_CYCLES(8), .TRIG_QUAL_CYCLES(4), .COUNT_W(16)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_pin(gate_pin),
    .external_trigger_pin(external_trigger_pin), .standby_key(standby_key), .panel_mode_valid(panel_mode_valid),
    .panel_mode(panel_mode), .output_enable(output_enable), .standby(standby), .trigger_event(trigger_event),
    .irq(irq));
  ogt_ext_equipment ext (.pclk(pclk), .gate_pin(gate_pin), .external_trigger_pin(external_trigger_pin));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (trigger_event === 1'b1) n_trig++;
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    report_and_stop();
  end

  task automatic report_and_stop;
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      errors++;
      report_and_stop();
    end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk
  task automatic wait_oe(input logic exp);
    for (int k = 0; k < 60; k++) begin
      @(posedge pclk);
      if (output_enable === exp) break;
    end
    check(output_enable, exp);
    if (output_enable !== exp) report_and_stop();
  endtask : wait_oe
  task automatic pulse_key;
    @(posedge pclk) standby_key <= 1'b1;
    @(posedge pclk) standby_key <= 1'b0;
  endtask : pulse_key
  task automatic set_mode(input logic [2:0] m, input logic panel);
    if (panel) begin
      @(posedge pclk);
      panel_mode <= m; panel_mode_valid <= 1'b1;
      @(posedge pclk) panel_mode_valid <= 1'b0;
    end else apb(1'b1, ogt_pkg::MODE_OFFSET, {29'h0, m});
    rd_chk(ogt_pkg::MODE_OFFSET, {29'h0, m});
  endtask : set_mode

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    standby_key = 1'b0; panel_mode_valid = 1'b0; panel_mode = 3'h0;
    repeat (16) @(posedge pclk);
    check({output_enable, standby, irq, trigger_event}, 4'h4);
    presetn <= 1'b1;
    rd_chk(ogt_pkg::MODE_OFFSET, 32'h0);
    rd_chk(ogt_pkg::IRQ_ENABLE_OFFSET, 32'h0);
    rd_chk(ogt_pkg::STATUS_OFFSET, 32'h0000_001C);
    // ****************************************
    // Mode table
    // ****************************************
    for (int i = 0; i < 6; i++) begin
      ext.drive_gate(!rows[i].act, 20);
      set_mode(rows[i].mode, i[0]);
      apb(1'b1, ogt_pkg::COMMAND_OFFSET, 32'h1);
      wait_oe(1'b1);
      ext.drive_gate(rows[i].act, 30);
      check(output_enable, rows[i].oe_act);
      ext.drive_gate(!rows[i].act, 30);
      check(output_enable, rows[i].oe_back);
      apb(1'b1, ogt_pkg::COMMAND_OFFSET, 32'h1);
      wait_oe(1'b1);
    end
    // ****************************************
    // Hand-written cases
    // ****************************************
    set_mode(ogt_pkg::HIGH_ENABLES_CODE, 1'b0);
    ext.drive_gate(1'b0, 5);
    ext.drive_gate(1'b1, 30);
    check(output_enable, 1'b1);
    set_mode(ogt_pkg::LOW_LATCH_OFF_CODE, 1'b1);
    ext.drive_gate(1'b0, 30);
    check(output_enable, 1'b0);
    rd_chk(ogt_pkg::STATUS_OFFSET, 32'h0000_001A);
    apb(1'b1, ogt_pkg::COMMAND_OFFSET, 32'h1);
    pulse_key();
    repeat (20) @(posedge pclk);
    check(output_enable, 1'b0);
    ext.drive_gate(1'b1, 30);
    check(output_enable, 1'b0);
    pulse_key();
    wait_oe(1'b1);
    pulse_key();
    wait_oe(1'b0);
    apb(1'b1, ogt_pkg::COMMAND_OFFSET, 32'h1);
    wait_oe(1'b1);
    apb(1'b1, ogt_pkg::COMMAND_OFFSET, 32'h2);
    wait_oe(1'b0);
    apb(1'b1, ogt_pkg::MODE_OFFSET, 32'h6);
    rd_chk(ogt_pkg::MODE_OFFSET, 32'h3);
    apb(1'b1, ogt_pkg::IRQ_ENABLE_OFFSET, 32'h1);
    ext.drive_trig(1'b0, 40);
    check(n_trig, 1);
    check(irq, 1'b1);
    rd_chk(ogt_pkg::TRIG_COUNT_OFFSET, 32'h1);
    apb(1'b1, ogt_pkg::IRQ_CLEAR_OFFSET, 32'h1);
    repeat (20) @(posedge pclk);
    check({n_trig[3:0], irq}, 5'h2);
    rd_chk(ogt_pkg::STATUS_OFFSET, 32'h0000_0004);
    ext.drive_trig(1'b1, 20);
    ext.drive_trig(1'b0, 20);
    check(n_trig, 2);
    ext.drive_trig(1'b1, 20);
    ext.drive_trig(1'b0, 2);
    ext.drive_trig(1'b1, 20);
    check(n_trig, 2);
    apb(1'b1, ogt_pkg::TRIG_COUNT_OFFSET, 32'h5);
    rd_chk(ogt_pkg::TRIG_COUNT_OFFSET, 32'h2);
    apb(1'b1, ogt_pkg::IRQ_ENABLE_OFFSET, 32'h0);
    @(posedge pclk);
    check(irq, 1'b0);
    rd_chk(ogt_pkg::IRQ_STATUS_OFFSET, 32'h7);
    rd_chk(8'h40, 32'h0);
    check(er, 1'b1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
